// *** aop_pkg.sv ***
// Constants for the alarm output pulser: register map, field positions, defaults and timing.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
package aop_pkg;
    // Register byte offsets
    localparam logic [4:0] CFG_OFS = 5'h00;
    localparam logic [4:0] ON_OFS = 5'h04;
    localparam logic [4:0] OFF_OFS = 5'h08;
    localparam logic [4:0] CMD_OFS = 5'h0C;
    localparam logic [4:0] STAT_OFS = 5'h10;
    localparam logic [4:0] ACT_OFS = 5'h14;
    // Field positions
    localparam int CFG_POL_LOW_BIT = 0;
    localparam int CFG_STEADY_BIT = 1;
    localparam int CMD_CONFIRM_BIT = 0;
    localparam int CMD_CANCEL_BIT = 1;
    localparam int CMD_DEFAULTS_BIT = 2;
    localparam int STAT_POL_BIT = 0;
    localparam int STAT_STEADY_BIT = 1;
    localparam int STAT_ALARM_BIT = 2;
    localparam int STAT_LINE_BIT = 3;
    localparam int STAT_ON_BIT = 4;
    localparam int STAT_OFF_BIT = 5;
    localparam int ACT_OFF_LSB = 16;
    localparam int DUR_W = 16;
    // Reset and default values
    localparam logic DEF_POL_LOW = 1'h0;
    localparam logic DEF_STEADY = 1'h0;
    localparam logic [15:0] DEF_ON_S = 16'h0005;
    localparam logic [15:0] DEF_OFF_S = 16'h0005;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_S = 1;
    localparam int NS_PER_S = 1000000000;
    localparam int SEC_CYCLES = TICK_TIME_S * (NS_PER_S / CLK_PERIOD_NS);
    // AHB
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    // Pulse phase states
    typedef enum logic [2:0] {
        AOP_IDLE = 3'h1,
        AOP_ON = 3'h2,
        AOP_OFF = 3'h4
    } aop_phase_e;
endpackage : aop_pkg

// *** aop_alarm_pulser.sv ***
// Alarm output pulser: drives the single alarm line from the internal alarm condition.
// Assumes alarm_in comes from logic on ref_clk_in; registers reached over AHB-Lite as the only slave.
// Contract
// - Active-high polarity: line low when idle, high during alarm.
// - Active-low polarity: line high when idle, low during alarm.
// - Restoring defaults makes polarity active-high.
// - Continuous mode holds the active level for the whole alarm.
// - Pulsed mode alternates active and idle levels while alarm persists.
// - Restoring defaults selects pulsed mode.
// - Each active phase is followed by an idle phase of off-duration, default 5 s.
// - Edits are staged, applied together on confirm, discarded on cancel.
// - Each active phase lasts the on-duration, default 5 s.
module aop_alarm_pulser #(
    parameter int unsigned SEC_CYCLES = aop_pkg::SEC_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic alarm_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    output logic alarm_line_out
);
    localparam int PW = (SEC_CYCLES > 1) ? $clog2(SEC_CYCLES) : 1;
    localparam int DW = aop_pkg::DUR_W;

    if (SEC_CYCLES < 2) begin : g_check
        $error("SEC_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic wr_pend;
        logic [4:0] wr_ofs;
        logic stg_pol;
        logic stg_steady;
        logic [DW-1:0] stg_on;
        logic [DW-1:0] stg_off;
        logic act_pol;
        logic act_steady;
        logic [DW-1:0] act_on;
        logic [DW-1:0] act_off;
        aop_pkg::aop_phase_e phase;
        logic [PW-1:0] pre;
        logic [DW-1:0] secs;
        logic line;
        logic [31:0] rdata;
    } aop_state_s;

    aop_state_s st_reg;
    aop_state_s st_next;

    // Zero duration is served as one second
    function automatic logic [DW-1:0] aop_len(input logic [DW-1:0] d);
        aop_len = (d == '0) ? {{(DW-1){1'b0}}, 1'b1} : d;
    endfunction : aop_len

    function automatic logic [31:0] aop_read(input aop_state_s s, input logic [4:0] ofs, input logic alarm);
        aop_read = 32'h0000_0000;
        case (ofs)
            aop_pkg::CFG_OFS: begin
                aop_read[aop_pkg::CFG_POL_LOW_BIT] = s.stg_pol;
                aop_read[aop_pkg::CFG_STEADY_BIT] = s.stg_steady;
            end
            aop_pkg::ON_OFS: aop_read[DW-1:0] = s.stg_on;
            aop_pkg::OFF_OFS: aop_read[DW-1:0] = s.stg_off;
            aop_pkg::STAT_OFS: begin
                aop_read[aop_pkg::STAT_POL_BIT] = s.act_pol;
                aop_read[aop_pkg::STAT_STEADY_BIT] = s.act_steady;
                aop_read[aop_pkg::STAT_ALARM_BIT] = alarm;
                aop_read[aop_pkg::STAT_LINE_BIT] = s.line;
                aop_read[aop_pkg::STAT_ON_BIT] = (s.phase == aop_pkg::AOP_ON);
                aop_read[aop_pkg::STAT_OFF_BIT] = (s.phase == aop_pkg::AOP_OFF);
            end
            aop_pkg::ACT_OFS: aop_read = {s.act_off, s.act_on};
            default: aop_read = 32'h0000_0000;
        endcase
    endfunction : aop_read

    logic addr_ok;
    logic tick;
    logic last_sec;
    logic [DW-1:0] cur_len;

    always_comb begin
        st_next = st_reg;
        addr_ok = hsel_in && hready_in && (htrans_in == aop_pkg::HTRANS_NONSEQ || htrans_in == aop_pkg::HTRANS_SEQ);
        // Bus data phase: writes land, reads answer with zero wait states
        st_next.wr_pend = addr_ok && hwrite_in;
        st_next.wr_ofs = haddr_in[4:0];
        st_next.rdata = (addr_ok && !hwrite_in) ? aop_read(st_reg, {haddr_in[4:2], 2'b00}, alarm_in) : 32'h0000_0000;
        if (st_reg.wr_pend) begin
            case ({st_reg.wr_ofs[4:2], 2'b00})
                aop_pkg::CFG_OFS: begin
                    st_next.stg_pol = hwdata_in[aop_pkg::CFG_POL_LOW_BIT];
                    st_next.stg_steady = hwdata_in[aop_pkg::CFG_STEADY_BIT];
                end
                aop_pkg::ON_OFS: st_next.stg_on = hwdata_in[DW-1:0];
                aop_pkg::OFF_OFS: st_next.stg_off = hwdata_in[DW-1:0];
                aop_pkg::CMD_OFS: begin
                    if (hwdata_in[aop_pkg::CMD_DEFAULTS_BIT]) begin
                        st_next.stg_pol = aop_pkg::DEF_POL_LOW;
                        st_next.act_pol = aop_pkg::DEF_POL_LOW;
                        st_next.stg_steady = aop_pkg::DEF_STEADY;
                        st_next.act_steady = aop_pkg::DEF_STEADY;
                        st_next.stg_on = aop_pkg::DEF_ON_S;
                        st_next.act_on = aop_pkg::DEF_ON_S;
                        st_next.stg_off = aop_pkg::DEF_OFF_S;
                        st_next.act_off = aop_pkg::DEF_OFF_S;
                    end else if (hwdata_in[aop_pkg::CMD_CONFIRM_BIT]) begin
                        st_next.act_pol = st_reg.stg_pol;
                        st_next.act_steady = st_reg.stg_steady;
                        st_next.act_on = st_reg.stg_on;
                        st_next.act_off = st_reg.stg_off;
                    end else if (hwdata_in[aop_pkg::CMD_CANCEL_BIT]) begin
                        st_next.stg_pol = st_reg.act_pol;
                        st_next.stg_steady = st_reg.act_steady;
                        st_next.stg_on = st_reg.act_on;
                        st_next.stg_off = st_reg.act_off;
                    end
                end
                default: st_next.wr_pend = 1'b0;
            endcase
            st_next.wr_pend = addr_ok && hwrite_in;
        end
        // Phase timer
        tick = (st_reg.pre == PW'(SEC_CYCLES - 1));
        cur_len = (st_reg.phase == aop_pkg::AOP_ON) ? aop_len(st_reg.act_on) : aop_len(st_reg.act_off);
        // A duration shortened mid-phase still ends the phase at the next tick
        last_sec = tick && (st_reg.secs >= cur_len - 1'b1);
        st_next.pre = tick ? '0 : st_reg.pre + 1'b1;
        st_next.secs = tick ? st_reg.secs + 1'b1 : st_reg.secs;
        case (st_reg.phase)
            aop_pkg::AOP_IDLE: begin
                st_next.pre = '0;
                st_next.secs = '0;
                if (alarm_in) begin
                    st_next.phase = aop_pkg::AOP_ON;
                end
            end
            aop_pkg::AOP_ON: begin
                if (!alarm_in) begin
                    st_next.phase = aop_pkg::AOP_IDLE;
                    st_next.pre = '0;
                    st_next.secs = '0;
                end else if (st_reg.act_steady) begin
                    st_next.pre = '0;
                    st_next.secs = '0;
                end else if (last_sec) begin
                    st_next.phase = aop_pkg::AOP_OFF;
                    st_next.secs = '0;
                end
            end
            aop_pkg::AOP_OFF: begin
                if (!alarm_in) begin
                    st_next.phase = aop_pkg::AOP_IDLE;
                    st_next.pre = '0;
                    st_next.secs = '0;
                end else if (last_sec || st_reg.act_steady) begin
                    st_next.phase = aop_pkg::AOP_ON;
                    st_next.pre = '0;
                    st_next.secs = '0;
                end
            end
            default: begin
                st_next.phase = aop_pkg::AOP_IDLE;
                st_next.pre = '0;
                st_next.secs = '0;
            end
        endcase
        // Active level follows polarity
        st_next.line = (st_next.phase == aop_pkg::AOP_ON) ^ st_next.act_pol;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '{wr_pend: 1'b0, wr_ofs: 5'h00, stg_pol: aop_pkg::DEF_POL_LOW, stg_steady: aop_pkg::DEF_STEADY,
                        stg_on: aop_pkg::DEF_ON_S, stg_off: aop_pkg::DEF_OFF_S, act_pol: aop_pkg::DEF_POL_LOW,
                        act_steady: aop_pkg::DEF_STEADY, act_on: aop_pkg::DEF_ON_S, act_off: aop_pkg::DEF_OFF_S,
                        phase: aop_pkg::AOP_IDLE, pre: '0, secs: '0, line: 1'b0, rdata: 32'h0000_0000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = st_reg.rdata;
    assign alarm_line_out = st_reg.line;

    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    logic cmd_wr;
    assign cmd_wr = st_reg.wr_pend && ({st_reg.wr_ofs[4:2], 2'b00} == aop_pkg::CMD_OFS);

    sequence s_rise_seen;
        !alarm_in ##1 alarm_in && st_reg.phase == aop_pkg::AOP_IDLE;
    endsequence
    sequence s_first_active;
        st_reg.phase == aop_pkg::AOP_ON && st_reg.pre == '0 && st_reg.secs == '0;
    endsequence

    a_idle_low_high: assert property (st_reg.phase != aop_pkg::AOP_ON && !st_reg.act_pol |-> !alarm_line_out)
        else $error("idle line not low with active-high polarity");
    a_idle_high_low: assert property (st_reg.phase != aop_pkg::AOP_ON && st_reg.act_pol |-> alarm_line_out)
        else $error("idle line not high with active-low polarity");
    a_defaults_pol: assert property (cmd_wr && hwdata_in[aop_pkg::CMD_DEFAULTS_BIT] |=> !st_reg.act_pol && !st_reg.stg_pol)
        else $error("defaults did not select active-high");
    a_steady_hold: assert property (st_reg.phase == aop_pkg::AOP_ON && st_reg.act_steady && alarm_in
                                    |=> st_reg.phase == aop_pkg::AOP_ON && alarm_line_out == !st_reg.act_pol)
        else $error("continuous mode dropped the active level");
    a_pulse_level: assert property (st_reg.phase == aop_pkg::AOP_OFF |-> alarm_line_out == st_reg.act_pol)
        else $error("off phase not at idle level");
    a_defaults_mode: assert property (cmd_wr && hwdata_in[aop_pkg::CMD_DEFAULTS_BIT] |=> !st_reg.act_steady)
        else $error("defaults did not select pulsed mode");
    a_off_end: assert property (st_reg.phase == aop_pkg::AOP_OFF && alarm_in && !st_reg.act_steady && last_sec
                                |=> st_reg.phase == aop_pkg::AOP_ON)
        else $error("off phase did not end after off-duration");
    a_confirm_apply: assert property (cmd_wr && hwdata_in[aop_pkg::CMD_CONFIRM_BIT] && !hwdata_in[aop_pkg::CMD_DEFAULTS_BIT]
                                      |=> st_reg.act_on == $past(st_reg.stg_on) && st_reg.act_pol == $past(st_reg.stg_pol))
        else $error("confirm did not apply staged set");
    a_on_end: assert property (st_reg.phase == aop_pkg::AOP_ON && alarm_in && !st_reg.act_steady && last_sec
                               |=> st_reg.phase == aop_pkg::AOP_OFF ##0 st_reg.secs == '0)
        else $error("on phase did not end after on-duration");
    a_rise_start: assert property (s_rise_seen |=> s_first_active)
        else $error("alarm rise did not start an active phase");
    a_clear_idle: assert property (!alarm_in && st_reg.phase != aop_pkg::AOP_IDLE
                                   |=> st_reg.phase == aop_pkg::AOP_IDLE && st_reg.pre == '0 && st_reg.secs == '0)
        else $error("alarm clear did not return to idle");
endmodule : aop_alarm_pulser

// *** aop_siren_model.sv ***
// Far-side alarm installation: a siren that sounds while the alarm line is at its active level.
// Assumes the installer set the siren to the same polarity as the pulser.
module aop_siren_model (
    input wire logic line_in,
    input wire logic pol_low_in,
    output logic sounding_out
);
    timeunit 1ns;
    timeprecision 100ps;
    assign sounding_out = line_in ^ pol_low_in;
endmodule : aop_siren_model

// *** tb_alarm_output_pulser.sv ***
// Self-checking bench for the alarm output pulser: AHB-Lite register access and alarm line timing.
// Assumes the pulser is the only AHB slave and a shortened second of 4 clock cycles.
module tb_alarm_output_pulser;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SEC = 4;
    logic ref_clk_in = 1'h0;
    logic rstn_in = 1'h0;
    logic alarm_in = 1'h0;
    logic hsel_in = 1'h0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic hwrite_in = 1'h0;
    logic [2:0] hsize_in = 3'h2;
    logic [31:0] hwdata_in = 32'h0;
    logic hreadyout_out;
    logic hresp_out;
    logic [31:0] hrdata_out;
    logic alarm_line_out;
    logic pol_low = 1'h0;
    logic sounding;
    int mismatches = 0;
    int checks_done = 0;
    int n;
    logic [31:0] rd;

    aop_alarm_pulser #(.SEC_CYCLES(SEC)) dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .alarm_in(alarm_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .hrdata_out(hrdata_out), .alarm_line_out(alarm_line_out));
    aop_siren_model siren (.line_in(alarm_line_out), .pol_low_in(pol_low), .sounding_out(sounding));

    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One single-word transfer; ready and read data are taken from the settled value before each edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rdv);
        int k;
        logic ok;
        @(posedge ref_clk_in);
        hsel_in <= 1'h1;
        haddr_in <= {27'h0, a};
        hwrite_in <= wr;
        htrans_in <= aop_pkg::HTRANS_NONSEQ;
        for (int p = 0; p < 2; p++) begin
            k = 0;
            do begin
                @(negedge ref_clk_in);
                ok = hreadyout_out;
                rdv = hrdata_out;
                @(posedge ref_clk_in);
                k++;
            end while (ok !== 1'h1 && k < 50);
            if (k >= 50) mismatches++;
            if (p == 0) begin
                htrans_in <= 2'h0;
                hwdata_in <= wd;
            end
        end
        chk({31'h0, hresp_out}, 32'h0);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'h1, a, d, rd);
    endtask : wr

    task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0, rd);
        chk(rd, exp);
    endtask : rchk

    task automatic alarm_set(input logic v);
        @(posedge ref_clk_in);
        alarm_in <= v;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk({31'h0, sounding}, {31'h0, v});
    endtask : alarm_set

    // Length of the next run of the siren at the given state, in cycles
    task automatic run(input logic lvl, input int exp);
        int w;
        w = 0;
        n = 0;
        while (sounding !== lvl && w < 200) begin
            @(negedge ref_clk_in);
            w++;
        end
        while (sounding === lvl && n < 300) begin
            n++;
            @(negedge ref_clk_in);
        end
        chk(32'(n), 32'(exp));
    endtask : run

    localparam logic [31:0] CONFIRM = 32'h1 << aop_pkg::CMD_CONFIRM_BIT;
    localparam logic [31:0] POL_LOW = 32'h1 << aop_pkg::CFG_POL_LOW_BIT;
    localparam logic [31:0] DEF_ACT = {aop_pkg::DEF_OFF_S, aop_pkg::DEF_ON_S};
    localparam int DEF_RUN = 5 * SEC;
    localparam logic [31:0] STAT_IDLE_LOW = (32'h1 << aop_pkg::STAT_POL_BIT) | (32'h1 << aop_pkg::STAT_STEADY_BIT)
        | (32'h1 << aop_pkg::STAT_LINE_BIT);

    initial begin
        repeat (10) @(posedge ref_clk_in);
        rstn_in <= 1'h1;
        rchk(aop_pkg::CFG_OFS, 32'h0);
        rchk(aop_pkg::ACT_OFS, DEF_ACT);
        chk({31'h0, alarm_line_out}, 32'h0);
        alarm_set(1'h1);
        run(1'h1, DEF_RUN);
        run(1'h0, DEF_RUN);
        alarm_set(1'h0);
        chk({31'h0, alarm_line_out}, 32'h0);
        alarm_set(1'h1);
        run(1'h1, DEF_RUN);
        alarm_set(1'h0);
        wr(aop_pkg::ON_OFS, 32'h2);
        wr(aop_pkg::OFF_OFS, 32'h3);
        wr(aop_pkg::CFG_OFS, POL_LOW);
        rchk(aop_pkg::ACT_OFS, DEF_ACT);
        wr(aop_pkg::CMD_OFS, 32'h1 << aop_pkg::CMD_CANCEL_BIT);
        rchk(aop_pkg::CFG_OFS, 32'h0);
        rchk(aop_pkg::ON_OFS, 32'h5);
        wr(aop_pkg::ON_OFS, 32'h2);
        wr(aop_pkg::OFF_OFS, 32'h3);
        wr(aop_pkg::CFG_OFS, POL_LOW);
        wr(aop_pkg::CMD_OFS, CONFIRM);
        rchk(aop_pkg::ACT_OFS, 32'h0003_0002);
        pol_low = 1'h1;
        chk({31'h0, alarm_line_out}, 32'h1);
        alarm_set(1'h1);
        run(1'h1, 2 * SEC);
        run(1'h0, 3 * SEC);
        alarm_set(1'h0);
        wr(aop_pkg::CFG_OFS, POL_LOW | (32'h1 << aop_pkg::CFG_STEADY_BIT));
        wr(aop_pkg::CMD_OFS, CONFIRM);
        alarm_set(1'h1);
        fork
            begin
                repeat (29) @(posedge ref_clk_in);
                alarm_in <= 1'h0;
            end
            run(1'h1, 30);
        join
        rchk(aop_pkg::STAT_OFS, STAT_IDLE_LOW);
        wr(aop_pkg::CMD_OFS, 32'h1 << aop_pkg::CMD_DEFAULTS_BIT);
        pol_low = 1'h0;
        rchk(aop_pkg::CFG_OFS, 32'h0);
        rchk(aop_pkg::ACT_OFS, DEF_ACT);
        rchk(aop_pkg::CMD_OFS, 32'h0);
        rchk(5'h1C, 32'h0);
        chk({31'h0, alarm_line_out}, 32'h0);
        alarm_set(1'h1);
        run(1'h1, DEF_RUN);
        alarm_set(1'h0);
        wr(aop_pkg::ON_OFS, 32'h0);
        wr(aop_pkg::CMD_OFS, CONFIRM);
        alarm_set(1'h1);
        run(1'h1, SEC);
        alarm_set(1'h0);
        report_and_stop();
    end

    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
endmodule : tb_alarm_output_pulser
